// ---- pkg/avc_cfg.svh ----
// Register offsets, field positions, reset values and bus answers of the coefficient bank.
`ifndef RELEASE_COEF_CFG_SVH
`define RELEASE_COEF_CFG_SVH
// Register indices; the byte address on the bus is four times the index.
`define IDX_RELEASE_RATE 10'h12A
`define IDX_B1_UPPER 10'h12C
`define IDX_B1_LOWER 10'h12E
`define IDX_B2_UPPER 10'h130
`define IDX_B2_LOWER 10'h132
`define IDX_A1_UPPER 10'h134
`define IDX_A1_LOWER 10'h136
`define IDX_A2_UPPER 10'h138
`define IDX_A2_LOWER 10'h13A
// Address bits that carry the index.
`define ADDR_W 12
`define IDX_MSB 11
`define IDX_LSB 2
// Field widths.
`define RATE_W 12
`define UPPER_W 16
`define LOWER_W 4
`define COEF_W 20
// Reset values.
`define RATE_RST 12'h050
`define UPPER_RST 16'h0000
`define LOWER_RST 4'h0
// Sample release-rate codes: 32, 8, 4 and 2 dB/s.
`define RATE_32DBS 12'h284
`define RATE_8DBS 12'h0A0
`define RATE_4DBS 12'h050
`define RATE_2DBS 12'h028
// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- pkg/avc_regs_pkg.sv ----
// Types shared by the release-rate and filter-coefficient register bank.
package volume_regs_pkg;
  // One filter coefficient as software stages it: upper word and lower nibble.
  typedef struct packed {
    logic [15:0] upper;
    logic [3:0] lower;
  } coef_t;
  // Register selected by a bus address.
  typedef enum logic [3:0] {
    SEL_RATE = 4'b0000,
    SEL_B1_UP = 4'b0001,
    SEL_B1_LO = 4'b0010,
    SEL_B2_UP = 4'b0011,
    SEL_B2_LO = 4'b0100,
    SEL_A1_UP = 4'b0101,
    SEL_A1_LO = 4'b0110,
    SEL_A2_UP = 4'b0111,
    SEL_A2_LO = 4'b1000,
    SEL_NONE = 4'b1001
  } reg_sel_t;
endpackage

// ---- core/avc_coef_regs.sv ----
// AXI4-Lite register bank for the volume release rate and biquad coefficients.
`timescale 1ns/1ps
`include "avc_cfg.svh"
//
// Overview of operation
// R1 - Twelve-bit release rate, reset 0x50, read-write.
// R2 - Software encodes rate from dB/s and sample rate.
// R3 - Codes 0x284/0xA0/0x50/0x28 mean 32/8/4/2 dB/s.
// R4 - Upper word holds coefficient bits 19:4.
// R5 - Lower word holds bits 3:0; rest reads zero.
// R6 - Coefficient is upper word above lower nibble.
//
module release_coef_regs
  import volume_regs_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic RSTN_IN,
  input wire logic [11:0] AWADDR_IN,
  input wire logic AWVALID_IN,
  output logic AWREADY_OUT,
  input wire logic [31:0] WDATA_IN,
  input wire logic [3:0] WSTRB_IN,
  input wire logic WVALID_IN,
  output logic WREADY_OUT,
  output logic [1:0] BRESP_OUT,
  output logic BVALID_OUT,
  input wire logic BREADY_IN,
  input wire logic [11:0] ARADDR_IN,
  input wire logic ARVALID_IN,
  output logic ARREADY_OUT,
  output logic [31:0] RDATA_OUT,
  output logic [1:0] RRESP_OUT,
  output logic RVALID_OUT,
  input wire logic RREADY_IN,
  output logic [11:0] RELEASE_RATE_OUT,
  output logic [19:0] COEF_B1_OUT,
  output logic [19:0] COEF_B2_OUT,
  output logic [19:0] COEF_A1_OUT,
  output logic [19:0] COEF_A2_OUT
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Maps a byte address onto the register it selects.
  function automatic reg_sel_t decode(input logic [11:0] addr);
    logic [9:0] idx;
    idx = addr[`IDX_MSB:`IDX_LSB];
    case (idx)
      `IDX_RELEASE_RATE: decode = SEL_RATE;
      `IDX_B1_UPPER: decode = SEL_B1_UP;
      `IDX_B1_LOWER: decode = SEL_B1_LO;
      `IDX_B2_UPPER: decode = SEL_B2_UP;
      `IDX_B2_LOWER: decode = SEL_B2_LO;
      `IDX_A1_UPPER: decode = SEL_A1_UP;
      `IDX_A1_LOWER: decode = SEL_A1_LO;
      `IDX_A2_UPPER: decode = SEL_A2_UP;
      `IDX_A2_LOWER: decode = SEL_A2_LO;
      default: decode = SEL_NONE;
    endcase
  endfunction

  // Merges the two low byte lanes of a write into a 16-bit register.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = data[15:8];
    end
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------

  logic [11:0] rate_q; // Release rate code.
  logic [11:0] rate_d; // Next release rate code.
  coef_t b1_q; // Coefficient b1 as staged.
  coef_t b1_d; // Next b1.
  coef_t b2_q; // Coefficient b2 as staged.
  coef_t b2_d; // Next b2.
  coef_t a1_q; // Coefficient a1 as staged.
  coef_t a1_d; // Next a1.
  coef_t a2_q; // Coefficient a2 as staged.
  coef_t a2_d; // Next a2.

  // ----------------------------------------------------------------
  // Write channel state
  // ----------------------------------------------------------------

  logic aw_have_q; // A write address is held.
  logic aw_have_d; // Next held flag.
  logic [11:0] aw_addr_q; // Held write address.
  logic [11:0] aw_addr_d; // Next held write address.
  logic w_have_q; // Write data is held.
  logic w_have_d; // Next held flag.
  logic [31:0] w_data_q; // Held write data.
  logic [31:0] w_data_d; // Next held write data.
  logic [3:0] w_strb_q; // Held byte strobes.
  logic [3:0] w_strb_d; // Next held byte strobes.
  logic awready_q; // Registered address ready.
  logic awready_d; // Next address ready.
  logic wready_q; // Registered data ready.
  logic wready_d; // Next data ready.
  logic bvalid_q; // Write response pending.
  logic bvalid_d; // Next response flag.
  logic [1:0] bresp_q; // Write response code.
  logic [1:0] bresp_d; // Next response code.
  reg_sel_t wsel; // Register addressed by the held write.
  // Merged image of the rate register; only its low twelve bits are kept.
  logic [15:0] rate_merge; // Rate word after byte lanes are merged.

  // ----------------------------------------------------------------
  // Write path and register update
  // ----------------------------------------------------------------

  // Collects address and data in either order, then applies the write
  // once both are held and no earlier response is still waiting.
  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d = w_have_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rate_d = rate_q;
    b1_d = b1_q;
    b2_d = b2_q;
    a1_d = a1_q;
    a2_d = a2_q;
    wsel = decode(aw_addr_q);
    // The rate is merged as a 16-bit word so its lanes behave like the others.
    rate_merge = merge16({4'h0, rate_q}, w_data_q, w_strb_q);
    // The response is retired when the master accepts it.
    if (bvalid_q && BREADY_IN) begin
      bvalid_d = 1'b0;
    end
    // Address capture.
    if (AWVALID_IN && awready_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = AWADDR_IN;
    end
    // Data capture.
    if (WVALID_IN && wready_q) begin
      w_have_d = 1'b1;
      w_data_d = WDATA_IN;
      w_strb_d = WSTRB_IN;
    end
    // Commit the write when both halves are in and the response slot is free.
    if (aw_have_q && w_have_q && !bvalid_q) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `RESP_OKAY;
      unique case (wsel)
        // Only the twelve rate bits are stored; the top nibble stays zero.
        SEL_RATE: rate_d = rate_merge[11:0]; // R1
        SEL_B1_UP: b1_d.upper = merge16(b1_q.upper, w_data_q, w_strb_q); // R4
        SEL_B2_UP: b2_d.upper = merge16(b2_q.upper, w_data_q, w_strb_q); // R4
        SEL_A1_UP: a1_d.upper = merge16(a1_q.upper, w_data_q, w_strb_q); // R4
        SEL_A2_UP: a2_d.upper = merge16(a2_q.upper, w_data_q, w_strb_q); // R4
        // Lower words keep only bits 3:0, which sit in byte lane 0.
        SEL_B1_LO: b1_d.lower = w_strb_q[0] ? w_data_q[3:0] : b1_q.lower; // R5
        SEL_B2_LO: b2_d.lower = w_strb_q[0] ? w_data_q[3:0] : b2_q.lower; // R5
        SEL_A1_LO: a1_d.lower = w_strb_q[0] ? w_data_q[3:0] : a1_q.lower; // R5
        SEL_A2_LO: a2_d.lower = w_strb_q[0] ? w_data_q[3:0] : a2_q.lower; // R5
        // Unmapped addresses change nothing and answer with an error.
        SEL_NONE: bresp_d = `RESP_SLVERR;
      endcase
    end
    // A channel is ready again only while nothing of its kind is held.
    awready_d = !aw_have_d;
    wready_d = !w_have_d;
  end

  // Registers the write path and the bank contents.
  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_have_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      rate_q <= `RATE_RST; // R1
      b1_q <= {`UPPER_RST, `LOWER_RST};
      b2_q <= {`UPPER_RST, `LOWER_RST};
      a1_q <= {`UPPER_RST, `LOWER_RST};
      a2_q <= {`UPPER_RST, `LOWER_RST};
    end else begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q <= w_have_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rate_q <= rate_d;
      b1_q <= b1_d;
      b2_q <= b2_d;
      a1_q <= a1_d;
      a2_q <= a2_d;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------

  logic arready_q; // Registered read address ready.
  logic arready_d; // Next read address ready.
  logic rvalid_q; // Read data pending.
  logic rvalid_d; // Next read data flag.
  logic [31:0] rdata_q; // Read data word.
  logic [31:0] rdata_d; // Next read data word.
  logic [1:0] rresp_q; // Read response code.
  logic [1:0] rresp_d; // Next read response code.

  // Takes one read address at a time and answers on the next edge.
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    // The data beat is retired when the master accepts it.
    if (rvalid_q && RREADY_IN) begin
      rvalid_d = 1'b0;
    end
    if (ARVALID_IN && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = `RESP_OKAY;
      // Unused and reserved bits always read as zero.
      unique case (decode(ARADDR_IN))
        SEL_RATE: rdata_d = {20'h00000, rate_q}; // R1
        SEL_B1_UP: rdata_d = {16'h0000, b1_q.upper}; // R4
        SEL_B2_UP: rdata_d = {16'h0000, b2_q.upper}; // R4
        SEL_A1_UP: rdata_d = {16'h0000, a1_q.upper}; // R4
        SEL_A2_UP: rdata_d = {16'h0000, a2_q.upper}; // R4
        SEL_B1_LO: rdata_d = {28'h0000000, b1_q.lower}; // R5
        SEL_B2_LO: rdata_d = {28'h0000000, b2_q.lower}; // R5
        SEL_A1_LO: rdata_d = {28'h0000000, a1_q.lower}; // R5
        SEL_A2_LO: rdata_d = {28'h0000000, a2_q.lower}; // R5
        SEL_NONE: begin
          rdata_d = 32'h00000000;
          rresp_d = `RESP_SLVERR;
        end
      endcase
    end
    // A new address is taken only while no data beat is waiting.
    arready_d = !rvalid_d;
  end

  // Registers the read channel.
  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Bus handshakes come straight from their flip-flops.
  assign AWREADY_OUT = awready_q;
  assign WREADY_OUT = wready_q;
  assign BVALID_OUT = bvalid_q;
  assign BRESP_OUT = bresp_q;
  assign ARREADY_OUT = arready_q;
  assign RVALID_OUT = rvalid_q;
  assign RDATA_OUT = rdata_q;
  assign RRESP_OUT = rresp_q;

  // The release rate is passed on as stored; the volume control reads
  // it as a per-sample step, so 0x284 is 32 dB/s and 0x50 is 4 dB/s.
  assign RELEASE_RATE_OUT = rate_q; // R3

  // Each coefficient joins its upper word above its lower nibble.
  assign COEF_B1_OUT = {b1_q.upper, b1_q.lower}; // R6
  assign COEF_B2_OUT = {b2_q.upper, b2_q.lower}; // R6
  assign COEF_A1_OUT = {a1_q.upper, a1_q.lower}; // R6
  assign COEF_A2_OUT = {a2_q.upper, a2_q.lower}; // R6

endmodule

// ---- tb/avc_coef_regs_monitor.sv ----
// Concurrent checks on the bus and output ports of the coefficient register bank.
`timescale 1ns/1ps
`include "avc_cfg.svh"
module release_coef_regs_monitor
  import volume_regs_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic RSTN_IN,
  input wire logic [11:0] AWADDR_IN,
  input wire logic AWVALID_IN,
  input wire logic AWREADY_OUT,
  input wire logic [31:0] WDATA_IN,
  input wire logic [3:0] WSTRB_IN,
  input wire logic WVALID_IN,
  input wire logic WREADY_OUT,
  input wire logic [1:0] BRESP_OUT,
  input wire logic BVALID_OUT,
  input wire logic BREADY_IN,
  input wire logic [11:0] ARADDR_IN,
  input wire logic ARVALID_IN,
  input wire logic ARREADY_OUT,
  input wire logic [31:0] RDATA_OUT,
  input wire logic [1:0] RRESP_OUT,
  input wire logic RVALID_OUT,
  input wire logic RREADY_IN,
  input wire logic [11:0] RELEASE_RATE_OUT,
  input wire logic [19:0] COEF_B1_OUT,
  input wire logic [19:0] COEF_B2_OUT,
  input wire logic [19:0] COEF_A1_OUT,
  input wire logic [19:0] COEF_A2_OUT
);
  // ----------------------------------------
  // Assertions, all in the bus clock domain
  // ----------------------------------------
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RSTN_IN);
  // Outputs leave reset at their documented values.
  a_reset_out_values: assert property ($rose(RSTN_IN) |-> RELEASE_RATE_OUT == `RATE_RST
    && (COEF_B1_OUT | COEF_B2_OUT | COEF_A1_OUT | COEF_A2_OUT) == 20'h00000)
    else $error("outputs wrong after reset");
  // Reserved upper half of every read word is zero.
  a_read_upper_zero: assert property (RVALID_OUT |-> RDATA_OUT[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  // A stalled write answer holds its code.
  a_bresp_held: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
    else $error("write answer dropped or changed");
  // A stalled read answer holds its data.
  a_rdata_held: assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT))
    else $error("read answer dropped or changed");
  // Read answer one edge after the address handshake.
  a_read_latency: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT)
    else $error("read answer late");
  // Write answer two edges after a joint address and data handshake.
  a_write_latency: assert property (AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT
    |-> ##2 BVALID_OUT) else $error("write answer late");
  // Stored values change only at a write commit.
  a_out_change_commit: assert property ($changed({RELEASE_RATE_OUT, COEF_B1_OUT,
    COEF_B2_OUT, COEF_A1_OUT, COEF_A2_OUT}) |-> $rose(BVALID_OUT))
    else $error("output changed without a write");
  // No new read address is taken while an answer is pending.
  a_ar_closed: assert property (RVALID_OUT |-> !ARREADY_OUT)
    else $error("read address open while answer pending");
  // A refused read returns zero data.
  a_slverr_zero: assert property (RVALID_OUT && RRESP_OUT == `RESP_SLVERR |->
    RDATA_OUT == 32'h00000000) else $error("refused read returned data");
  // ----------------------------------------
  // Coverage of the main scenarios
  // ----------------------------------------
  c_write_done: cover property (BVALID_OUT && BREADY_IN);
  c_read_refused: cover property (RVALID_OUT && RREADY_IN && RRESP_OUT == `RESP_SLVERR);
  c_rate_changed: cover property ($changed(RELEASE_RATE_OUT));
endmodule
bind release_coef_regs release_coef_regs_monitor mon (.MCLK_IN(MCLK_IN), .RSTN_IN(RSTN_IN),
  .AWADDR_IN(AWADDR_IN), .AWVALID_IN(AWVALID_IN), .AWREADY_OUT(AWREADY_OUT),
  .WDATA_IN(WDATA_IN), .WSTRB_IN(WSTRB_IN), .WVALID_IN(WVALID_IN), .WREADY_OUT(WREADY_OUT),
  .BRESP_OUT(BRESP_OUT), .BVALID_OUT(BVALID_OUT), .BREADY_IN(BREADY_IN),
  .ARADDR_IN(ARADDR_IN), .ARVALID_IN(ARVALID_IN), .ARREADY_OUT(ARREADY_OUT),
  .RDATA_OUT(RDATA_OUT), .RRESP_OUT(RRESP_OUT), .RVALID_OUT(RVALID_OUT),
  .RREADY_IN(RREADY_IN), .RELEASE_RATE_OUT(RELEASE_RATE_OUT), .COEF_B1_OUT(COEF_B1_OUT),
  .COEF_B2_OUT(COEF_B2_OUT), .COEF_A1_OUT(COEF_A1_OUT), .COEF_A2_OUT(COEF_A2_OUT));

// ---- tb/testbench.sv ----
// Self-checking bench for the release-rate and coefficient register bank.
`timescale 1ns/1ps
`include "avc_cfg.svh"
module testbench;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic mclk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [11:0] rate;
  logic [19:0] coef [4];
  int error_cnt, samples_checked, cycles;
  // The design under test.
  release_coef_regs dut (.MCLK_IN(mclk), .RSTN_IN(rstn), .AWADDR_IN(awaddr),
    .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(wstrb),
    .WVALID_IN(wvalid), .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid),
    .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
    .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready),
    .RELEASE_RATE_OUT(rate), .COEF_B1_OUT(coef[0]), .COEF_B2_OUT(coef[1]),
    .COEF_A1_OUT(coef[2]), .COEF_A2_OUT(coef[3]));
  // ----------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------
  // The 25 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // A hang is cut short after a cycle ceiling far above the run's length.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      results();
    end
  end
  // Compares one value and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One write; the answer is stalled a cycle before it is accepted.
  task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge mclk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge mclk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (!bvalid);
    bready <= 1'b1;
    @(posedge mclk);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  // One read; the answer is stalled a cycle before it is accepted.
  task automatic rd(input logic [9:0] idx, input logic [31:0] ed, input logic [1:0] er);
    @(posedge mclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge mclk); while (!rvalid);
    rready <= 1'b1;
    @(posedge mclk);
    rready <= 1'b0;
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset values at the ports and through the bus.
  task automatic t_reset();
    chk({20'h0, rate}, 32'h00000050);
    rd(`IDX_RELEASE_RATE, 32'h00000050, `RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      chk({12'h0, coef[k]}, 32'h0);
      rd(`IDX_B1_UPPER + 10'(4 * k), 32'h0, `RESP_OKAY);
      rd(`IDX_B1_LOWER + 10'(4 * k), 32'h0, `RESP_OKAY);
    end
    $display("test reset done");
  endtask
  // Every sample rate code, with junk in the reserved bits.
  task automatic t_rate();
    logic [11:0] codes [4];
    codes = '{12'h284, 12'h0A0, 12'h050, 12'h028};
    foreach (codes[i]) begin
      wr(`IDX_RELEASE_RATE, {16'hA5A5, 4'hF, codes[i]}, `RESP_OKAY);
      rd(`IDX_RELEASE_RATE, {20'h0, codes[i]}, `RESP_OKAY);
      chk({20'h0, rate}, {20'h0, codes[i]});
    end
    $display("test rate done");
  endtask
  // Each coefficient pair, then a recheck that no write touched another.
  task automatic t_coef();
    logic [19:0] exp [4];
    for (int k = 0; k < 4; k++) begin
      exp[k] = {16'h9C30 ^ 16'(k * 16'h1111), 4'(k + 5)};
      wr(`IDX_B1_UPPER + 10'(4 * k), {16'hFFFF, exp[k][19:4]}, `RESP_OKAY);
      wr(`IDX_B1_LOWER + 10'(4 * k), {28'hFFFFFFF, exp[k][3:0]}, `RESP_OKAY);
      rd(`IDX_B1_UPPER + 10'(4 * k), {16'h0, exp[k][19:4]}, `RESP_OKAY);
      rd(`IDX_B1_LOWER + 10'(4 * k), {28'h0, exp[k][3:0]}, `RESP_OKAY);
    end
    for (int k = 0; k < 4; k++) begin
      chk({12'h0, coef[k]}, {12'h0, exp[k]});
    end
    $display("test coef done");
  endtask
  // Byte strobes: lane 1 alone changes only the upper byte of b1.
  task automatic t_strobe();
    wstrb <= 4'h2;
    wr(`IDX_B1_UPPER, 32'hFFFF1234, `RESP_OKAY);
    wr(`IDX_B1_LOWER, 32'h0000000F, `RESP_OKAY);
    wstrb <= 4'hF;
    rd(`IDX_B1_UPPER, 32'h00001230, `RESP_OKAY);
    rd(`IDX_B1_LOWER, 32'h00000005, `RESP_OKAY);
    chk({12'h0, coef[0]}, 32'h00012305);
    $display("test strobe done");
  endtask
  // Unmapped places are refused and change nothing.
  task automatic t_bad();
    wr(10'h12B, 32'h00000FFF, `RESP_SLVERR);
    rd(10'h12B, 32'h0, `RESP_SLVERR);
    rd(10'h000, 32'h0, `RESP_SLVERR);
    chk({20'h0, rate}, 32'h00000028);
    $display("test unmapped done");
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Main sequence: idle inputs, reset for three cycles, then the scenarios.
  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 56'h0;
    wstrb = 4'hF;
    error_cnt = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    t_reset();
    t_rate();
    t_coef();
    t_strobe();
    t_bad();
    results();
  end
endmodule
